// *** rtl/plsr_consts.svh ***
`ifndef PLSR_CONSTS_SVH
`define PLSR_CONSTS_SVH
`define PLSR_STAGES 8
`define PLSR_LAST 7
`endif

// *** rtl/plsr_pkg.sv ***
`include "plsr_consts.svh"
package plsr_pkg;
   typedef struct packed {
      logic [`PLSR_STAGES-1:0] stage;
      logic [2:0] clk_sync;
      logic [2:0] inh_sync;
      logic clk_seen;
      logic inh_seen;
   } plsr_state_t;
endpackage

// *** rtl/plsr_shift_register.sv ***
`timescale 1ns/10ps
`include "plsr_consts.svh"
module plsr_shift_register
   import plsr_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // Pins in
   input wire logic shift_not_load,
   input wire logic shift_clock,
   input wire logic clock_inhibit,
   input wire logic chain_input,
   input wire logic [`PLSR_STAGES-1:0] parallel_in,
   // Pins out
   output logic last_stage_out,
   output logic last_stage_out_n
);
   plsr_state_t state_reg;
   plsr_state_t state_next;
   logic clk_filt;
   logic inh_filt;
   logic shift_fire;
   logic [`PLSR_STAGES-1:0] stage_d;

   // Filtered pin levels: change counts once stages 2 and 3 agree
   always_comb
   begin
      clk_filt = state_reg.clk_seen;
      inh_filt = state_reg.inh_seen;
      if (state_reg.clk_sync[1] == state_reg.clk_sync[2])
      begin
         clk_filt = state_reg.clk_sync[2];
      end
      if (state_reg.inh_sync[1] == state_reg.inh_sync[2])
      begin
         inh_filt = state_reg.inh_sync[2];
      end
      // Either input rising while the other is low
      shift_fire = (clk_filt & ~state_reg.clk_seen & ~inh_filt) |
         (inh_filt & ~state_reg.inh_seen & ~clk_filt);
   end

   // Per-stage next value: load, shift or hold
   generate
      for (genvar i = 0; i < `PLSR_STAGES; i++)
      begin : g_stage
         logic shift_src;
         if (i == 0)
         begin : g_first
            assign shift_src = chain_input;
         end
         else
         begin : g_rest
            assign shift_src = state_reg.stage[i-1];
         end
         assign stage_d[i] = !shift_not_load ?
            parallel_in[i] :
            (shift_fire ?
            shift_src :
            state_reg.stage[i]);
      end
   endgenerate

   always_comb
   begin
      state_next = state_reg;
      state_next.clk_sync = {state_reg.clk_sync[1:0], shift_clock};
      state_next.inh_sync = {state_reg.inh_sync[1:0], clock_inhibit};
      state_next.clk_seen = clk_filt;
      state_next.inh_seen = inh_filt;
      state_next.stage = stage_d;
   end

   // Stages are not reset; while rst is high they still load or shift when clk_en is set
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg.clk_sync <= 3'h0;
         state_reg.inh_sync <= 3'h7;
         state_reg.clk_seen <= 1'h0;
         state_reg.inh_seen <= 1'h1;
         if (clk_en)
         begin
            state_reg.stage <= state_next.stage;
         end
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
      end
   end

   // Load is transparent to the outputs, as the part is asynchronous
   always_comb
   begin
      if (!shift_not_load)
      begin
         last_stage_out = parallel_in[`PLSR_LAST];
      end
      else
      begin
         last_stage_out = state_reg.stage[`PLSR_LAST];
      end
      last_stage_out_n = ~last_stage_out;
   end

   chk_out_complement: assert property (@(posedge clk) disable iff (rst)
      last_stage_out_n == ~last_stage_out)
      else $error("complement output mismatch");
   chk_load_follow: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !shift_not_load) |=> state_reg.stage == $past(parallel_in))
      else $error("load did not capture inputs");
   chk_load_output: assert property (@(posedge clk) disable iff (rst)
      !shift_not_load |-> last_stage_out == parallel_in[`PLSR_LAST])
      else $error("load output wrong");
   chk_hold_idle: assert property (@(posedge clk) disable iff (rst)
      (clk_en && shift_not_load && !shift_fire) |=> $stable(state_reg.stage))
      else $error("stages changed without edge");
   chk_shift_move: assert property (@(posedge clk) disable iff (rst)
      (clk_en && shift_not_load && shift_fire) |=>
      state_reg.stage == {$past(state_reg.stage[`PLSR_LAST-1:0]),
      $past(chain_input)})
      else $error("shift wrong");
   chk_shift_out: assert property (@(posedge clk) disable iff (rst)
      shift_not_load |-> last_stage_out == state_reg.stage[`PLSR_LAST])
      else $error("output not last stage");
   chk_inhibit_block: assert property (@(posedge clk) disable iff (rst)
      (inh_filt && state_reg.inh_seen) |-> !shift_fire)
      else $error("shift while inhibited");
   chk_edge_symm: assert property (@(posedge clk) disable iff (rst)
      (inh_filt && !state_reg.inh_seen && !clk_filt) |-> shift_fire)
      else $error("inhibit edge ignored");

   chk_drop_last: assert property (@(posedge clk) disable iff (rst)
      (clk_en && shift_not_load && shift_fire) |=>
      state_reg.stage[`PLSR_LAST] ==
      $past(state_reg.stage[`PLSR_LAST-1]))
      else $error("final stage not replaced");

   chk_first_stage: assert property (@(posedge clk) disable iff (rst)
      (clk_en && shift_not_load && shift_fire) |=>
      state_reg.stage[0] == $past(chain_input))
      else $error("chain input not taken");

   chk_load_first: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !shift_not_load) |=>
      state_reg.stage[0] == $past(parallel_in[0]))
      else $error("first stage load wrong");

   chk_load_last: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !shift_not_load) |=>
      state_reg.stage[`PLSR_LAST] == $past(parallel_in[`PLSR_LAST]))
      else $error("final stage load wrong");

   chk_clock_block: assert property (@(posedge clk) disable iff (rst)
      (clk_filt && state_reg.clk_seen) |->
      !shift_fire)
      else $error("shift while clock high");

   chk_clock_edge: assert property (@(posedge clk) disable iff (rst)
      (clk_filt && !state_reg.clk_seen && !inh_filt) |->
      shift_fire)
      else $error("clock edge ignored");

   chk_one_shift: assert property (@(posedge clk) disable iff (rst)
      (clk_en && shift_fire) |=>
      !shift_fire)
      else $error("one edge gave two shifts");

   chk_clk_filter: assert property (@(posedge clk) disable iff (rst)
      (clk_filt != state_reg.clk_seen) |->
      (state_reg.clk_sync[1] == state_reg.clk_sync[2]))
      else $error("clock change before stages agree");

   chk_inh_filter: assert property (@(posedge clk) disable iff (rst)
      (inh_filt != state_reg.inh_seen) |->
      (state_reg.inh_sync[1] == state_reg.inh_sync[2]))
      else $error("inhibit change before stages agree");

   chk_clk_seen: assert property (@(posedge clk) disable iff (rst)
      clk_en |=>
      state_reg.clk_seen == $past(clk_filt))
      else $error("clock level not recorded");

   chk_inh_seen: assert property (@(posedge clk) disable iff (rst)
      clk_en |=>
      state_reg.inh_seen == $past(inh_filt))
      else $error("inhibit level not recorded");

   chk_reset_edges: assert property (@(posedge clk)
      rst |=>
      (!state_reg.clk_seen && state_reg.inh_seen))
      else $error("edge detect not reset");

   chk_freeze_hold: assert property (@(posedge clk) disable iff (rst)
      !clk_en |=>
      $stable(state_reg))
      else $error("state moved while disabled");

   chk_load_inverse: assert property (@(posedge clk) disable iff (rst)
      !shift_not_load |->
      last_stage_out_n == ~parallel_in[`PLSR_LAST])
      else $error("load inverse output wrong");
endmodule

// *** test/plsr_ctrl_model.sv ***
`timescale 1ns/10ps
module plsr_ctrl_model
(
   // System
   input wire logic clk,
   // Pins driven
   output logic shift_clock,
   output logic clock_inhibit
);
   initial
   begin
      shift_clock = 1'b0;
      clock_inhibit = 1'b0;
   end
   // One rising edge on the chosen pin, each level 4 clk
   task automatic pulse(input logic on_inh);
      @(posedge clk);
      if (on_inh)
         clock_inhibit <= 1'b1;
      else
         shift_clock <= 1'b1;
      repeat (4) @(posedge clk);
      if (on_inh)
         clock_inhibit <= 1'b0;
      else
         shift_clock <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic set_inh(input logic v);
      @(posedge clk);
      clock_inhibit <= v;
      repeat (4) @(posedge clk);
   endtask
endmodule

// *** test/plsr_shift_register_tb.sv ***
`timescale 1ns/10ps
module plsr_shift_register_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic shift_not_load = 1'b0;
   logic chain_input = 1'b0;
   logic [7:0] parallel_in = 8'h00;
   logic [7:0] e;
   logic shift_clock, clock_inhibit, last_stage_out, last_stage_out_n;
   int n_errors = 0;
   int checks_done = 0;
   always #25 clk = ~clk;
   plsr_shift_register dut (.clk(clk), .rst(rst), .clk_en(clk_en),
      .shift_not_load(shift_not_load), .shift_clock(shift_clock),
      .clock_inhibit(clock_inhibit), .chain_input(chain_input),
      .parallel_in(parallel_in), .last_stage_out(last_stage_out),
      .last_stage_out_n(last_stage_out_n));
   plsr_ctrl_model ctl (.clk(clk), .shift_clock(shift_clock),
      .clock_inhibit(clock_inhibit));
   task automatic chk(input logic v);
      #1;
      checks_done++;
      if (last_stage_out !== v || last_stage_out_n !== ~v)
      begin
         n_errors++;
         $display("Error %0t: serial output mismatch", $time);
      end
   endtask
   task automatic load(input logic [7:0] p);
      @(posedge clk);
      shift_not_load <= 1'b0;
      parallel_in <= p;
      e = p;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_load;
      load(8'hA5);
      chk(1'b1);
      load(8'h5A);
      chk(1'b0);
   endtask
   task automatic t_shift;
      load(8'hB1);
      shift_not_load <= 1'b1;
      repeat (8) @(posedge clk);
      chk(e[7]);
      for (int i = 0; i < 10; i++)
      begin
         chain_input <= i[1];
         e = {e[6:0], i[1]};
         ctl.pulse(i[0]);
         chk(e[7]);
      end
   endtask
   task automatic t_inhibit;
      load(8'h5C);
      ctl.set_inh(1'b1);
      shift_not_load <= 1'b1;
      ctl.pulse(1'b0);
      chk(e[7]);
      ctl.set_inh(1'b0);
      ctl.pulse(1'b0);
      e = {e[6:0], chain_input};
      chk(e[7]);
   endtask
   task automatic t_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      ctl.pulse(1'b0);
      clk_en <= 1'b1;
      repeat (4) @(posedge clk);
      chk(e[7]);
   endtask
   task automatic t_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(e[7]);
   endtask
   task automatic complete_run;
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_load();
      t_shift();
      t_inhibit();
      t_freeze();
      t_reset();
      complete_run();
   end
endmodule
